/* File: core/metering_event_interrupt_unit.sv */
// Contract
// - enabled pending event drives irq_n low
// - enable register at 0x40, resets 0x00
// - enable bits 6..0, bit 7 zero
// - results refresh raises update event
// - any event sets its flag bit
// - flags set regardless of enable bits
// - flag register 0x41 read-only, read clears
// - flag bits 6..0, bit 7 zero
// - copy register 0x42, bits 5..0, clear-on-read
// - same register access from SPI or UART
// - writes need 0xE5 to 0xEA first
// - overflow when accumulator wraps to zero
// - periodic freeze copy is freeze event
`timescale 1ns/1ps
`include "event_irq_map.svh"

module metering_event_interrupt_unit #(
  parameter int unsigned ACC_WIDTH     = `ACC_WIDTH,
  parameter int unsigned FREEZE_CYCLES = `FREEZE_CYCLES
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic                     ce,
  // register port shared by the serial front ends
  input  wire event_irq_pkg::reg_byte_t reg_addr,
  input  wire event_irq_pkg::reg_byte_t reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output event_irq_pkg::reg_byte_t      reg_rdata,
  output logic                          reg_rvalid,
  // metering events
  input  wire logic                     results_refresh,
  input  wire logic                     active_pulse_out,
  input  wire logic                     reactive_pulse_out,
  input  wire logic                     zero_cross_evt,
  input  wire logic [ACC_WIDTH-1:0]     active_energy,
  input  wire logic [ACC_WIDTH-1:0]     custom_energy,
  input  wire logic                     freeze_mode,
  // outputs
  output logic                          irq_n,
  output logic                          write_unlock_flag,
  output logic                          freeze_load,
  output logic                          soft_reset
);

  import event_irq_pkg::*;

  // ----------------------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------------------
  if (ACC_WIDTH < 2 || FREEZE_CYCLES < 2) begin : g_bad_params
    $error("accumulator width and freeze period must be at least two");
  end

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  reg_byte_t                enable;
  reg_byte_t                flags;
  reg_byte_t                copy;
  reg_byte_t                ev;
  reg_byte_t                next_rdata;
  logic [`EV_COUNT-1:0]     flag_bits;
  logic [`COPY_COUNT-1:0]   copy_bits;
  lock_state_e              lock_state;
  lock_state_e              next_lock_state;
  logic                     active_pulse_q;
  logic                     reactive_pulse_q;
  logic                     soft_rst_q;
  logic                     rd_flags;
  logic                     rd_copy;
  logic                     cmd_wr;
  logic                     en_req;
  logic                     en_wr;

  event_tick_if freeze_tick ();
  event_tick_if active_wrap ();
  event_tick_if custom_wrap ();

  // ----------------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------------
  function automatic logic addr_is(input reg_byte_t addr, input reg_byte_t target);
    return addr == target;
  endfunction

  assign rd_flags = reg_rd && addr_is(reg_addr, `ADDR_EVENT_FLAGS);
  assign rd_copy  = reg_rd && addr_is(reg_addr, `ADDR_EVENT_COPY);
  assign cmd_wr   = reg_wr && addr_is(reg_addr, `ADDR_COMMAND);
  assign en_req   = reg_wr && addr_is(reg_addr, `ADDR_EVENT_ENABLE);
  assign en_wr    = en_req && lock_state == UNLOCKED;

  // ----------------------------------------------------------------------------
  // event sources
  // ----------------------------------------------------------------------------
  freeze_timer #(
    .FREEZE_CYCLES (FREEZE_CYCLES)
  ) u_freeze_timer (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .ce          (ce),
    .freeze_mode (freeze_mode),
    .tick        (freeze_tick.src)
  );

  energy_wrap_detect #(
    .WIDTH (ACC_WIDTH)
  ) u_active_wrap (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .acc     (active_energy),
    .tick    (active_wrap.src)
  );

  energy_wrap_detect #(
    .WIDTH (ACC_WIDTH)
  ) u_custom_wrap (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .acc     (custom_energy),
    .tick    (custom_wrap.src)
  );

  assign freeze_load = freeze_tick.pulse;

  // pulse outputs count once per rising edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_pulse_q   <= 1'b0;
      reactive_pulse_q <= 1'b0;
    end else if (ce) begin
      active_pulse_q   <= active_pulse_out;
      reactive_pulse_q <= reactive_pulse_out;
    end
  end

  always_comb begin
    ev = `BYTE_ZERO;
    ev[`EV_UPDATE]         = results_refresh;
    ev[`EV_ACTIVE_PULSE]   = active_pulse_out && !active_pulse_q;
    ev[`EV_REACTIVE_PULSE] = reactive_pulse_out && !reactive_pulse_q;
    ev[`EV_ACTIVE_OVF]     = active_wrap.pulse;
    ev[`EV_CUSTOM_OVF]     = custom_wrap.pulse;
    ev[`EV_ZERO_CROSS]     = zero_cross_evt;
    ev[`EV_FREEZE]         = freeze_tick.pulse;
  end

  // ----------------------------------------------------------------------------
  // write protection
  // ----------------------------------------------------------------------------
  // host must unlock first
  always_comb begin
    next_lock_state = lock_state;
    case (lock_state)
      LOCKED: begin
        if (cmd_wr && reg_wdata == `CMD_UNLOCK) begin
          next_lock_state = UNLOCKED;
        end
      end
      UNLOCKED: begin
        if (cmd_wr && reg_wdata == `CMD_LOCK) begin
          next_lock_state = LOCKED;
        end
      end
      default: begin
        next_lock_state = LOCKED;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_state <= LOCKED;
    end else if (ce) begin
      if (soft_rst_q) begin
        lock_state <= LOCKED;
      end else begin
        lock_state <= next_lock_state;
      end
    end
  end

  assign write_unlock_flag = lock_state == UNLOCKED;

  // soft reset command, accepted only while unlocked
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      soft_rst_q <= 1'b0;
    end else if (ce) begin
      soft_rst_q <= cmd_wr && reg_wdata == `CMD_SOFT_RESET && lock_state == UNLOCKED;
    end
  end

  assign soft_reset = soft_rst_q;

  // ----------------------------------------------------------------------------
  // enable register
  // ----------------------------------------------------------------------------
  // enable register reset and write
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable <= `ENABLE_RESET;
    end else if (ce) begin
      if (soft_rst_q) begin
        enable <= `ENABLE_RESET;
      end else if (en_wr) begin
        enable <= reg_wdata & `ENABLE_MASK;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // flag and copy registers; a new event beats the read clear
  // ----------------------------------------------------------------------------
  for (genvar i = 0; i < `EV_COUNT; i++) begin : g_flag
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        flag_bits[i] <= 1'b0;
      end else if (ce) begin
        if (soft_rst_q) begin
          flag_bits[i] <= 1'b0;
        end else if (ev[i]) begin
          flag_bits[i] <= 1'b1;
        end else if (rd_flags) begin
          flag_bits[i] <= 1'b0;
        end
      end
    end
  end

  for (genvar i = 0; i < `COPY_COUNT; i++) begin : g_copy
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        copy_bits[i] <= 1'b0;
      end else if (ce) begin
        if (soft_rst_q) begin
          copy_bits[i] <= 1'b0;
        end else if (ev[i]) begin
          copy_bits[i] <= 1'b1;
        end else if (rd_copy) begin
          copy_bits[i] <= 1'b0;
        end
      end
    end
  end

  assign flags = {1'b0, flag_bits};
  assign copy  = {2'b00, copy_bits};

  // ----------------------------------------------------------------------------
  // interrupt pin
  // ----------------------------------------------------------------------------
  // enabled flag pulls low
  assign irq_n = ~|(flags & enable);

  // ----------------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------------
  always_comb begin
    next_rdata = `BYTE_ZERO;
    if (addr_is(reg_addr, `ADDR_EVENT_ENABLE)) begin
      next_rdata = enable;
    end else if (addr_is(reg_addr, `ADDR_EVENT_FLAGS)) begin
      next_rdata = flags;
    end else if (addr_is(reg_addr, `ADDR_EVENT_COPY)) begin
      next_rdata = copy;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata  <= `BYTE_ZERO;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  irq_on_event_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && !soft_rst_q && !en_wr && (ev & enable) != `BYTE_ZERO) |=> !irq_n)
    else $error("enabled event did not assert irq_n");

  locked_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && en_req && lock_state == LOCKED) |=> $stable(enable))
    else $error("enable register changed while locked");

  enable_write_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && en_wr && !soft_rst_q) |=> enable == ($past(reg_wdata) & `ENABLE_MASK))
    else $error("unlocked enable write not stored");

  enable_reserved_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && reg_rd && addr_is(reg_addr, `ADDR_EVENT_ENABLE)) |=> !reg_rdata[7])
    else $error("enable bit 7 read as one");

  update_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && results_refresh && !soft_rst_q) |=> flags[`EV_UPDATE])
    else $error("refresh did not set update flag");

  flag_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && !soft_rst_q && ev != `BYTE_ZERO) |=> (flags & $past(ev)) == $past(ev))
    else $error("event lost from flag register");

  disabled_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && enable == `ENABLE_RESET && !en_wr) |=> irq_n)
    else $error("irq_n low with all enables off");

  read_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && rd_flags && ev == `BYTE_ZERO) |=> flags == `BYTE_ZERO)
    else $error("flag read did not clear flags");

  read_return_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && rd_flags) |=> reg_rvalid && reg_rdata == $past(flags))
    else $error("flag read returned wrong value");

  copy_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && !soft_rst_q && zero_cross_evt) ##1 (ce && rd_copy)
      |=> reg_rdata[`EV_ZERO_CROSS] && reg_rdata[7:6] == 2'b00)
    else $error("copy register lost zero crossing");

  unlock_cmd_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && !soft_rst_q && cmd_wr && reg_wdata == `CMD_UNLOCK) |=> write_unlock_flag)
    else $error("unlock command not taken");

  irq_release_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && rd_flags && ev == `BYTE_ZERO) |=> irq_n)
    else $error("irq_n stayed low after flags cleared");

  freeze_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !ce |=> $stable(flags) && $stable(enable) && $stable(lock_state))
    else $error("state moved while clock enable low");

endmodule // metering_event_interrupt_unit

/* File: core/event_irq_map.svh */
`ifndef EVENT_IRQ_MAP_SVH
`define EVENT_IRQ_MAP_SVH

// ----------------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------------
`define ADDR_EVENT_ENABLE 8'h40
`define ADDR_EVENT_FLAGS  8'h41
`define ADDR_EVENT_COPY   8'h42
`define ADDR_COMMAND      8'hEA

// ----------------------------------------------------------------------------
// command codes written to the command register
// ----------------------------------------------------------------------------
`define CMD_UNLOCK        8'hE5
`define CMD_LOCK          8'hDC
`define CMD_SOFT_RESET    8'hFA

// ----------------------------------------------------------------------------
// reset values and implemented-bit masks
// ----------------------------------------------------------------------------
`define ENABLE_RESET      8'h00
`define BYTE_ZERO         8'h00
`define ENABLE_MASK       8'h7F

// ----------------------------------------------------------------------------
// event bit positions, shared by enable, flag and copy registers
// ----------------------------------------------------------------------------
`define EV_UPDATE         0
`define EV_ACTIVE_PULSE   1
`define EV_REACTIVE_PULSE 2
`define EV_ACTIVE_OVF     3
`define EV_CUSTOM_OVF     4
`define EV_ZERO_CROSS     5
`define EV_FREEZE         6
`define EV_COUNT          7
`define COPY_COUNT        6

// ----------------------------------------------------------------------------
// widths and timing
// ----------------------------------------------------------------------------
`define ACC_WIDTH         24
`define CLK_PERIOD_NS     50
`define FREEZE_PERIOD_NS  572139700
`define FREEZE_CYCLES     (`FREEZE_PERIOD_NS / `CLK_PERIOD_NS)

`endif

/* File: core/event_irq_pkg.sv */
package event_irq_pkg;

  // ----------------------------------------------------------------------------
  // shared types
  // ----------------------------------------------------------------------------
  typedef logic [7:0] reg_byte_t;

  typedef enum logic {
    LOCKED,
    UNLOCKED
  } lock_state_e;

endpackage

/* File: core/event_tick_if.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// one-cycle event pulse from a source module to the interrupt core
// ----------------------------------------------------------------------------
interface event_tick_if;
  logic pulse;

  modport src (output pulse);
  modport dst (input  pulse);
endinterface

/* File: core/freeze_timer.sv */
`timescale 1ns/1ps
`include "event_irq_map.svh"

module freeze_timer #(
  parameter int unsigned FREEZE_CYCLES = `FREEZE_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       ce,
  // control
  input  wire logic       freeze_mode,
  // event out
  event_tick_if.src       tick
);

  localparam int unsigned CW = $clog2(FREEZE_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(FREEZE_CYCLES - 1);
  localparam logic [CW-1:0] ONE  = CW'(1);

  logic [CW-1:0] count;

  // ----------------------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------------------
  if (FREEZE_CYCLES < 2) begin : g_bad_period
    $error("freeze period must be at least two cycles");
  end

  // ----------------------------------------------------------------------------
  // period counter, restarts whenever freezing is off
  // ----------------------------------------------------------------------------
  // periodic freeze copy
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
    end else if (ce) begin
      if (!freeze_mode || count == LAST) begin
        count <= '0;
      end else begin
        count <= count + ONE;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick.pulse <= 1'b0;
    end else if (ce) begin
      tick.pulse <= freeze_mode && count == LAST;
    end
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  freeze_spacing_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && tick.pulse) |=> !(ce && tick.pulse))
    else $error("freeze pulses closer than the period");

endmodule // freeze_timer

/* File: core/energy_wrap_detect.sv */
`timescale 1ns/1ps
`include "event_irq_map.svh"

module energy_wrap_detect #(
  parameter int unsigned WIDTH = `ACC_WIDTH
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             ce,
  // accumulator under watch
  input  wire logic [WIDTH-1:0] acc,
  // event out
  event_tick_if.src             tick
);

  logic [WIDTH-1:0] prev;
  logic             primed;

  // ----------------------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------------------
  if (WIDTH < 2) begin : g_bad_width
    $error("accumulator width must be at least two bits");
  end

  // ----------------------------------------------------------------------------
  // previous sample; primed keeps the reset value from faking a wrap
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev   <= '0;
      primed <= 1'b0;
    end else if (ce) begin
      prev   <= acc;
      primed <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick.pulse <= 1'b0;
    end else if (ce) begin
      tick.pulse <= primed && (&prev) && acc == '0;
    end
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  wrap_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && primed && (&prev) && acc == '0) |=> tick.pulse)
    else $error("accumulator wrap did not raise overflow");

endmodule // energy_wrap_detect

/* File: verif/host_port_model.sv */
`timescale 1ns/1ps
`include "event_irq_map.svh"

module host_port_model
  import event_irq_pkg::*;
(
  // clock
  input  wire logic      clk,
  // register port
  output reg_byte_t      reg_addr,
  output reg_byte_t      reg_wdata,
  output logic           reg_wr,
  output logic           reg_rd,
  input  wire reg_byte_t reg_rdata,
  input  wire logic      reg_rvalid
);
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  task automatic wr(input reg_byte_t a, input reg_byte_t d);
    @(posedge clk) #1;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge clk) #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input reg_byte_t a, output reg_byte_t d, output logic ok);
    @(posedge clk) #1;
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge clk) #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    ok       = reg_rvalid;
    d        = reg_rdata;
  endtask

  task automatic unlock();
    wr(`ADDR_COMMAND, `CMD_UNLOCK);
  endtask
endmodule // host_port_model

/* File: verif/metering_event_interrupt_unit_tb.sv */
`timescale 1ns/1ps
`include "event_irq_map.svh"

module metering_event_interrupt_unit_tb;
  import event_irq_pkg::*;

  localparam int unsigned FRZ  = 8;
  localparam int          TMAX = 20000;

  logic        clk     = 1'b0;
  logic        sys_rst = 1'b1;
  reg_byte_t   reg_addr, reg_wdata, reg_rdata, got, en;
  logic        reg_wr, reg_rd, reg_rvalid, ok;
  logic        refresh = 1'b0, apulse = 1'b0, rpulse = 1'b0, zcross = 1'b0, fmode = 1'b0;
  logic [23:0] aen = 24'h0, cen = 24'h0;
  logic        irq_n, unlocked, frz_load, srst;
  logic        ce = 1'b1;
  int          frz_seen = 0;
  logic [31:0] seed = 32'hD26A8591;
  logic [5:0]  m;
  int          err_total = 0;
  int          compares = 0;
  int          cycles = 0;

  metering_event_interrupt_unit #(.FREEZE_CYCLES(FRZ)) metering_event_interrupt_unit_i (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .results_refresh(refresh), .active_pulse_out(apulse), .reactive_pulse_out(rpulse),
    .zero_cross_evt(zcross), .active_energy(aen), .custom_energy(cen), .freeze_mode(fmode),
    .irq_n(irq_n), .write_unlock_flag(unlocked), .freeze_load(frz_load), .soft_reset(srst));

  host_port_model host_port_model_i (
    .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  always #25 clk = ~clk;

  always @(posedge clk) begin
    cycles++;
    if (cycles >= TMAX) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // expectations and helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  function automatic reg_byte_t irq_exp(input reg_byte_t f, input reg_byte_t e);
    return {7'h0, ~|(f & e & `ENABLE_MASK)};
  endfunction

  task automatic check(input string what, input reg_byte_t exp, input reg_byte_t seen);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rdchk(input reg_byte_t a, input reg_byte_t exp, input string what);
    host_port_model_i.rd(a, got, ok);
    check("rvalid", 8'h01, {7'h0, ok});
    check(what, exp, got);
  endtask

  // events by bit position: one cycle, overflow as a wrap
  task automatic fire(input logic [5:0] b);
    @(posedge clk) #1;
    {zcross, rpulse, apulse, refresh} = {b[5], b[2:0]};
    if (b[3]) aen = 24'hFFFFFF;
    if (b[4]) cen = 24'hFFFFFF;
    @(posedge clk) #1;
    {zcross, rpulse, apulse, refresh} = 4'h0;
    aen = 24'h0;
    cen = 24'h0;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic tally_and_finish();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    #1 sys_rst = 1'b0;
    check("irq_n idle", 8'h01, {7'h0, irq_n});
    rdchk(`ADDR_EVENT_ENABLE, `ENABLE_RESET, "enable reset");
    host_port_model_i.wr(`ADDR_EVENT_ENABLE, 8'hFF);
    rdchk(`ADDR_EVENT_ENABLE, 8'h00, "enable locked");
    host_port_model_i.unlock();
    check("unlock", 8'h01, {7'h0, unlocked});
    host_port_model_i.wr(`ADDR_EVENT_ENABLE, 8'hFF);
    rdchk(`ADDR_EVENT_ENABLE, 8'h7F, "enable bits");
    host_port_model_i.wr(`ADDR_EVENT_FLAGS, 8'hFF);
    rdchk(`ADDR_EVENT_FLAGS, 8'h00, "flags read only");
    rdchk(8'h55, 8'h00, "unmapped");
    host_port_model_i.wr(`ADDR_EVENT_ENABLE, 8'h00);
    for (int b = 0; b < 6; b++) begin
      fire(6'h01 << b);
      check("irq_n masked", 8'h01, {7'h0, irq_n});
      rdchk(`ADDR_EVENT_FLAGS, 8'h01 << b, "flag set");
      rdchk(`ADDR_EVENT_FLAGS, 8'h00, "flag cleared");
      rdchk(`ADDR_EVENT_COPY, 8'h01 << b, "copy set");
    end
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      en   = seed[7:0];
      m    = seed[13:8];
      host_port_model_i.wr(`ADDR_EVENT_ENABLE, en);
      fire(m);
      check("irq_n pending", irq_exp({2'b0, m}, en), {7'h0, irq_n});
      rdchk(`ADDR_EVENT_FLAGS, {2'b0, m}, "flags random");
      check("irq_n after read", 8'h01, {7'h0, irq_n});
      rdchk(`ADDR_EVENT_COPY, {2'b0, m}, "copy random");
    end
    host_port_model_i.wr(`ADDR_EVENT_ENABLE, 8'h40);
    fmode = 1'b1;
    repeat (2 * FRZ + 4) begin
      @(posedge clk) #1;
      if (frz_load === 1'b1) frz_seen++;
    end
    check("irq_n freeze", 8'h00, {7'h0, irq_n});
    check("freeze_load count", 8'((2 * FRZ + 4) / FRZ), 8'(frz_seen));
    fmode = 1'b0;
    repeat (3) @(posedge clk);
    rdchk(`ADDR_EVENT_FLAGS, 8'h40, "freeze flag");
    rdchk(`ADDR_EVENT_COPY, 8'h00, "copy no freeze");
    // clock enable low: events are not taken
    ce = 1'b0;
    fire(6'h21);
    ce = 1'b1;
    rdchk(`ADDR_EVENT_FLAGS, 8'h00, "flags frozen");
    rdchk(`ADDR_EVENT_COPY, 8'h00, "copy frozen");
    // zero crossing then copy read on the very next edge
    fork
      fire(6'h20);
      begin
        @(posedge clk);
        rdchk(`ADDR_EVENT_COPY, 8'h20, "copy back to back");
      end
    join
    rdchk(`ADDR_EVENT_FLAGS, 8'h20, "flag back to back");
    host_port_model_i.wr(`ADDR_COMMAND, `CMD_LOCK);
    check("lock", 8'h00, {7'h0, unlocked});
    host_port_model_i.wr(`ADDR_EVENT_ENABLE, 8'h3F);
    rdchk(`ADDR_EVENT_ENABLE, 8'h40, "enable relocked");
    host_port_model_i.wr(`ADDR_COMMAND, `CMD_SOFT_RESET);
    check("soft_reset locked", 8'h00, {7'h0, srst});
    host_port_model_i.unlock();
    host_port_model_i.wr(`ADDR_COMMAND, `CMD_SOFT_RESET);
    check("soft_reset", 8'h01, {7'h0, srst});
    repeat (3) @(posedge clk);
    check("lock after soft reset", 8'h00, {7'h0, unlocked});
    rdchk(`ADDR_EVENT_ENABLE, `ENABLE_RESET, "enable soft reset");
    tally_and_finish();
  end
endmodule // metering_event_interrupt_unit_tb
